// ==== coc_comparator_output_control.sv ====
`timescale 1ns/10ps
module coc_comparator_output_control
    import coc_pkg::*;
#(
    parameter int unsigned NUM_CMP = 2,
    parameter int unsigned PORT_W  = 8
) (
    input  wire logic                     ref_clk,
    input  wire logic                     resetn,
    input  wire logic [5:0]               avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    output logic      [31:0]              avs_readdata,
    output logic                          avs_waitrequest,
    input  wire logic [NUM_CMP-1:0]       cmp_raw,
    input  wire logic                     gate_tmr_clk,
    input  wire logic [PORT_W-1:0]        port_pins,
    output logic      [NUM_CMP-1:0]       cmp_out_ext,
    output logic      [NUM_CMP-1:0]       cmp_irq_flag,
    output logic      [NUM_CMP-1:0]       cmp_power_en,
    output logic      [NUM_CMP-1:0]       cmp_inputs_connect,
    output logic      [NUM_CMP-1:0]       cmp_speed_fast,
    output logic      [NUM_CMP-1:0]       cmp_hyst_en,
    output logic      [NUM_CMP*SEL_W-1:0] pos_input_sel,
    output logic      [NUM_CMP*SEL_W-1:0] neg_input_sel,
    output logic      [PORT_W-1:0]        analog_pin_sel
);

    localparam int unsigned FCW = $clog2(FILT_HOLD_CYC + 1);
    localparam logic [FCW-1:0] FILT_LOAD = FCW'(FILT_HOLD_CYC);

    // the register map has room for two comparators and a port up to 32 bits wide
    initial begin
        if (NUM_CMP < 1 || NUM_CMP > 2)
            $error("NUM_CMP must be 1 or 2");
        if (PORT_W < 1 || PORT_W > 32)
            $error("PORT_W must be 1 to 32");
    end

    function automatic logic [5:0] cmp_ofs(input logic [5:0] base,
                                           input int unsigned idx);
        cmp_ofs = base + 6'(idx) * OFS_CMP_STRIDE;
    endfunction

    // bus slave state
    logic              ack_q;
    logic              ack_d;
    logic [31:0]       rdata_q;
    logic [31:0]       rdata_d;

    // per comparator state
    logic [7:0]        ctrl0_q [NUM_CMP];
    logic [7:0]        ctrl0_d [NUM_CMP];
    logic [7:0]        ctrl1_q [NUM_CMP];
    logic [7:0]        ctrl1_d [NUM_CMP];
    logic [FCW-1:0]    fcnt_q  [NUM_CMP];
    logic [FCW-1:0]    fcnt_d  [NUM_CMP];
    logic [NUM_CMP-1:0] filt_q;
    logic [NUM_CMP-1:0] filt_d;
    logic [NUM_CMP-1:0] res_q;
    logic [NUM_CMP-1:0] res_d;
    logic [NUM_CMP-1:0] prev_q;
    logic [NUM_CMP-1:0] prev_d;
    logic [NUM_CMP-1:0] sync_q;
    logic [NUM_CMP-1:0] sync_d;
    logic [NUM_CMP-1:0] flag_q;
    logic [NUM_CMP-1:0] flag_d;
    logic [NUM_CMP-1:0] res_now;
    logic              tmr_prev_q;
    logic              tmr_prev_d;
    logic [PORT_W-1:0] analog_pin_sel_q;
    logic [PORT_W-1:0] analog_pin_sel_d;

    logic              req;
    logic              wr_go;
    logic              tmr_fall;

    // one wait state on every access; the write lands when waitrequest drops
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_go           = avs_write & ack_q;
    assign avs_readdata    = rdata_q;
    // prescaled gate timer clock, sampled; capture on its falling edge
    assign tmr_fall        = tmr_prev_q & ~gate_tmr_clk;

    always_comb begin
        ack_d      = req & ~ack_q;
        tmr_prev_d = gate_tmr_clk;
        analog_pin_sel_d    = analog_pin_sel_q;
        if (wr_go && avs_address == OFS_ANALOG_PIN_SEL)
            analog_pin_sel_d = avs_writedata[PORT_W-1:0];
        filt_d  = filt_q;
        res_d   = res_q;
        prev_d  = prev_q;
        sync_d  = sync_q;
        flag_d  = flag_q;
        res_now = '0;
        for (int i = 0; i < NUM_CMP; i++) begin
            logic gated;
            logic fnow;
            logic rise;
            logic fall;
            logic set;
            logic clr;
            gated = 1'b0;
            fnow  = 1'b0;
            rise  = 1'b0;
            fall  = 1'b0;
            set   = 1'b0;
            clr   = 1'b0;
            ctrl0_d[i] = ctrl0_q[i];
            ctrl1_d[i] = ctrl1_q[i];
            fcnt_d[i]  = fcnt_q[i];
            if (wr_go && avs_address == cmp_ofs(OFS_CTRL0_BASE, i))
                ctrl0_d[i] = avs_writedata[7:0] & CTRL0_WMASK;
            if (wr_go && avs_address == cmp_ofs(OFS_CTRL1_BASE, i))
                ctrl1_d[i] = avs_writedata[7:0];
            // a disabled comparator reads low before inversion, so
            // toggling enable or invert still moves the result
            gated = cmp_raw[i] & ctrl0_q[i][B_EN];
            // zero latency: a change passes at once, its reversal is held
            if (ctrl0_q[i][B_FILT] && fcnt_q[i] != '0)
                fnow = filt_q[i];
            else
                fnow = gated;
            filt_d[i] = fnow;
            if (fnow != filt_q[i])
                fcnt_d[i] = FILT_LOAD;
            else if (fcnt_q[i] != '0)
                fcnt_d[i] = fcnt_q[i] - 1'b1;
            res_now[i] = fnow ^ ctrl0_q[i][B_INV];
            res_d[i]   = res_now[i];
            prev_d[i]  = res_q[i];
            if (tmr_fall)
                sync_d[i] = res_now[i];
            rise = res_q[i] & ~prev_q[i];
            fall = ~res_q[i] & prev_q[i];
            set  = (rise & ctrl1_q[i][B_RISE]) |
                   (fall & ctrl1_q[i][B_FALL]);
            clr  = wr_go && avs_address == OFS_IRQ_FLAG &&
                   avs_writedata[i];
            // a new edge wins over the clearing write
            flag_d[i] = set | (flag_q[i] & ~clr);
        end
    end

    // read data is captured in the first cycle and stands at the ack edge
    always_comb begin
        rdata_d = rdata_q;
        if (avs_read && !ack_q) begin
            rdata_d = 32'h0000_0000;
            if (avs_address == OFS_MIRROR)
                rdata_d[NUM_CMP-1:0] = res_q;
            else if (avs_address == OFS_IRQ_FLAG)
                rdata_d[NUM_CMP-1:0] = flag_q;
            else if (avs_address == OFS_ANALOG_PIN_SEL)
                rdata_d[PORT_W-1:0] = analog_pin_sel_q;
            else if (avs_address == OFS_PORT)
                rdata_d[PORT_W-1:0] = port_pins & ~analog_pin_sel_q;
            for (int i = 0; i < NUM_CMP; i++) begin
                if (avs_address == cmp_ofs(OFS_CTRL0_BASE, i)) begin
                    rdata_d[7:0]   = ctrl0_q[i];
                    rdata_d[B_RES] = res_q[i];
                end
                if (avs_address == cmp_ofs(OFS_CTRL1_BASE, i))
                    rdata_d[7:0] = ctrl1_q[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack_q      <= 1'b0;
            rdata_q    <= 32'h0000_0000;
            tmr_prev_q <= 1'b0;
            analog_pin_sel_q    <= '1;
            filt_q     <= '0;
            res_q      <= '0;
            prev_q     <= '0;
            sync_q     <= '0;
            flag_q     <= '0;
            for (int i = 0; i < NUM_CMP; i++) begin
                ctrl0_q[i] <= CTRL0_RST;
                ctrl1_q[i] <= CTRL1_RST;
                fcnt_q[i]  <= '0;
            end
        end else begin
            ack_q      <= ack_d;
            rdata_q    <= rdata_d;
            tmr_prev_q <= tmr_prev_d;
            analog_pin_sel_q    <= analog_pin_sel_d;
            filt_q     <= filt_d;
            res_q      <= res_d;
            prev_q     <= prev_d;
            sync_q     <= sync_d;
            flag_q     <= flag_d;
            for (int i = 0; i < NUM_CMP; i++) begin
                ctrl0_q[i] <= ctrl0_d[i];
                ctrl1_q[i] <= ctrl1_d[i];
                fcnt_q[i]  <= fcnt_d[i];
            end
        end
    end

    // static controls to the analog side and the conditioned outputs
    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_out
            // the gate timer samples on its rising edge, away from capture
            assign cmp_out_ext[g] = ctrl0_q[g][B_SYNC] ?
                                    sync_q[g] : res_now[g];
            assign cmp_power_en[g]       = ctrl0_q[g][B_EN];
            assign cmp_inputs_connect[g] = ctrl0_q[g][B_EN];
            assign cmp_speed_fast[g]     = ctrl0_q[g][B_SPEED];
            assign cmp_hyst_en[g]        = ctrl0_q[g][B_HYS];
            assign pos_input_sel[g*SEL_W +: SEL_W] =
                ctrl1_q[g][PSEL_LSB +: SEL_W];
            assign neg_input_sel[g*SEL_W +: SEL_W] =
                ctrl1_q[g][NSEL_LSB +: SEL_W];
        end
    endgenerate

    assign cmp_irq_flag   = flag_q;
    assign analog_pin_sel = analog_pin_sel_q;

endmodule

// ==== coc_ctl_props.sv ====
`timescale 1ns/10ps
module coc_ctl_props
    import coc_pkg::*;
#(
    parameter int unsigned NUM_CMP = 2,
    parameter int unsigned PORT_W  = 8
) (
    input wire logic               ref_clk,
    input wire logic               resetn,
    input wire logic [5:0]         avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_writedata,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest,
    input wire logic [PORT_W-1:0]  port_pins,
    input wire logic [NUM_CMP-1:0] cmp_irq_flag,
    input wire logic [NUM_CMP-1:0] cmp_power_en,
    input wire logic [NUM_CMP-1:0] cmp_inputs_connect,
    input wire logic [NUM_CMP-1:0] cmp_speed_fast,
    input wire logic [PORT_W-1:0]  analog_pin_sel
);
    logic [PORT_W-1:0] port_exp_q;
    // read data is loaded one edge before the ack edge, so compare one back
    always_ff @(posedge ref_clk) port_exp_q <= port_pins & ~analog_pin_sel;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_rd(logic [5:0] a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    sequence s_held;
        (avs_read || avs_write) && avs_waitrequest ##1 avs_read || avs_write;
    endsequence
    wait_first_a: assert property ($rose(avs_read) |-> avs_waitrequest)
        else $error("no wait state on first read cycle");
    ack_next_a: assert property (s_held |-> !avs_waitrequest)
        else $error("held request not acked after one cycle");
    connect_en_a: assert property (cmp_inputs_connect == cmp_power_en)
        else $error("inputs connected while comparator off");
    reset_val_a: assert property ($rose(resetn) |->
        cmp_speed_fast == '1 && analog_pin_sel == '1)
        else $error("speed or analog select wrong after reset");
    flag_clear_a: assert property ($fell(cmp_irq_flag[0]) |->
        $past(avs_write) && $past(avs_address) == OFS_IRQ_FLAG &&
        $past(avs_writedata[0]) && !$past(avs_waitrequest))
        else $error("flag dropped without a clearing write");
    en_write_a: assert property ($changed(cmp_power_en) |->
        $past(avs_write) && !$past(avs_waitrequest))
        else $error("enable changed without a write");
    port_read_a: assert property (s_rd(OFS_PORT) |->
        avs_readdata[PORT_W-1:0] == port_exp_q)
        else $error("analog pin not read as zero");
    mirror_zero_a: assert property (s_rd(OFS_MIRROR) |->
        avs_readdata[31:NUM_CMP] == '0)
        else $error("mirror upper bits not zero");
    unmapped_a: assert property (s_rd(6'h3C) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind coc_comparator_output_control coc_ctl_props #(
    .NUM_CMP(NUM_CMP), .PORT_W(PORT_W)) u_props (
    .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_pins(port_pins),
    .cmp_irq_flag(cmp_irq_flag), .cmp_power_en(cmp_power_en),
    .cmp_inputs_connect(cmp_inputs_connect),
    .cmp_speed_fast(cmp_speed_fast), .analog_pin_sel(analog_pin_sel));

// ==== coc_pkg.sv ====
package coc_pkg;

    // clock and zero latency filter timing
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned FILT_HOLD_NS  = 20;
    // longest time: rounds down, but never below one cycle
    localparam int unsigned FILT_HOLD_RAW =
        (FILT_HOLD_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned FILT_HOLD_CYC =
        (FILT_HOLD_RAW < 1) ? 1 : FILT_HOLD_RAW;

    // register byte offsets on the bus
    localparam logic [5:0] OFS_CTRL0_BASE = 6'h00;
    localparam logic [5:0] OFS_CTRL1_BASE = 6'h04;
    localparam logic [5:0] OFS_CMP_STRIDE = 6'h08;
    localparam logic [5:0] OFS_MIRROR     = 6'h10;
    localparam logic [5:0] OFS_IRQ_FLAG   = 6'h14;
    localparam logic [5:0] OFS_ANALOG_PIN_SEL      = 6'h18;
    localparam logic [5:0] OFS_PORT       = 6'h1C;

    // primary control fields
    localparam int unsigned B_EN    = 7;
    localparam int unsigned B_RES   = 6;
    localparam int unsigned B_INV   = 4;
    localparam int unsigned B_FILT  = 3;
    localparam int unsigned B_SPEED = 2;
    localparam int unsigned B_HYS   = 1;
    localparam int unsigned B_SYNC  = 0;
    localparam logic [7:0]  CTRL0_RST   = 8'h04;
    localparam logic [7:0]  CTRL0_WMASK = 8'h9F;

    // secondary control fields
    localparam int unsigned B_RISE   = 7;
    localparam int unsigned B_FALL   = 6;
    localparam int unsigned PSEL_LSB = 3;
    localparam int unsigned NSEL_LSB = 0;
    localparam int unsigned SEL_W    = 3;
    localparam logic [7:0]  CTRL1_RST = 8'h00;

endpackage

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench
    import coc_pkg::*;
;
    logic        ref_clk, resetn, avs_read, avs_write, gate_tmr_clk;
    logic        avs_waitrequest;
    logic [5:0]  avs_address, pos_input_sel, neg_input_sel;
    logic [31:0] avs_writedata, avs_readdata, rd, r;
    logic [1:0]  cmp_raw, cmp_out_ext, cmp_irq_flag, cmp_power_en;
    logic [1:0]  cmp_inputs_connect, cmp_speed_fast, cmp_hyst_en;
    logic [7:0]  port_pins, analog_pin_sel, ans;
    int          fails, n_checks, k;
    coc_comparator_output_control DUT (
        .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmp_raw(cmp_raw),
        .gate_tmr_clk(gate_tmr_clk), .port_pins(port_pins),
        .cmp_out_ext(cmp_out_ext), .cmp_irq_flag(cmp_irq_flag),
        .cmp_power_en(cmp_power_en), .cmp_inputs_connect(cmp_inputs_connect),
        .cmp_speed_fast(cmp_speed_fast), .cmp_hyst_en(cmp_hyst_en),
        .pos_input_sel(pos_input_sel), .neg_input_sel(neg_input_sel),
        .analog_pin_sel(analog_pin_sel));
    function automatic logic res_exp(input logic raw, input logic inv);
        return raw ^ inv;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // every access starts right after an edge and holds until the ack edge
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
        // waitrequest and read data are sampled at the rising edge itself
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            fails++;
            stop_test();
        end
        rd = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        stop_test();
    end
    initial begin
        {resetn, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {cmp_raw, port_pins, fails, n_checks} = '0;
        gate_tmr_clk = 1'b1;
        void'($urandom(81375));
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        bus(0, OFS_CTRL0_BASE, 0);
        chk(rd, 32'h04);
        chk(32'(cmp_speed_fast), 32'h3);
        bus(0, OFS_ANALOG_PIN_SEL, 0);
        chk(rd, 32'hFF);
        $display("test reset values done");
        bus(1, OFS_CTRL0_BASE, 32'hFFFF_FFFF);
        bus(0, OFS_CTRL0_BASE, 0);
        chk(rd, 32'hDF);
        chk(32'({cmp_hyst_en[0], cmp_power_en[0]}), 32'h3);
        bus(1, OFS_CTRL0_BASE, 0);
        cyc(1);
        chk(32'({cmp_hyst_en[0], cmp_speed_fast[0]}), 32'h0);
        bus(1, OFS_CTRL1_BASE, 32'h3F);
        cyc(1);
        chk(32'({pos_input_sel[2:0], neg_input_sel[2:0]}), 32'h3F);
        $display("test control fields done");
        bus(1, OFS_CTRL0_BASE + OFS_CMP_STRIDE, 32'h80);
        for (k = 0; k < 8; k++) begin
            r = $urandom;
            if (k < 4) {r[2], r[0]} = k[1:0];
            bus(1, OFS_CTRL0_BASE, {24'h0, 3'h4, r[2], 4'h0});
            cmp_raw <= r[1:0];
            cyc(4);
            chk(32'(cmp_out_ext[0]), 32'(res_exp(r[0], r[2])));
            bus(0, OFS_MIRROR, 0);
            chk(rd, {30'h0, r[1], res_exp(r[0], r[2])});
            bus(0, OFS_CTRL0_BASE, 0);
            chk(32'(rd[6]), 32'(res_exp(r[0], r[2])));
        end
        $display("test polarity done");
        bus(1, OFS_CTRL0_BASE, 32'h80);
        cmp_raw <= 2'b00;
        for (k = 0; k < 4; k++) begin
            bus(1, OFS_CTRL1_BASE, (k < 2) ? 32'h80 : 32'h40);
            bus(1, OFS_IRQ_FLAG, 32'h3);
            cmp_raw[0] <= !k[0];
            cyc(4);
            chk(32'(cmp_irq_flag[0]), 32'(k == 0 || k == 3));
        end
        bus(1, OFS_IRQ_FLAG, 32'h1);
        cyc(1);
        chk(32'(cmp_irq_flag[0]), 32'h0);
        bus(1, OFS_CTRL0_BASE, 32'h00);
        bus(1, OFS_CTRL1_BASE, 32'h80);
        bus(1, OFS_IRQ_FLAG, 32'h3);
        bus(1, OFS_CTRL0_BASE, 32'h10);
        cyc(4);
        chk(32'(cmp_irq_flag[0]), 32'h1);
        $display("test edge flags done");
        for (k = 0; k < 6; k++) begin
            ans = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
            port_pins <= 8'($urandom);
            bus(1, OFS_ANALOG_PIN_SEL, {24'h0, ans});
            bus(0, OFS_PORT, 0);
            chk(rd, {24'h0, port_pins & ~ans});
        end
        bus(1, 6'h3C, 32'hFF);
        bus(0, 6'h3C, 0);
        chk(rd, 32'h0);
        $display("test port read done");
        bus(1, OFS_CTRL0_BASE, 32'h81);
        gate_tmr_clk <= 1'b0;
        @(posedge ref_clk);
        gate_tmr_clk <= 1'b1;
        cmp_raw[0] <= 1'b1;
        cyc(4);
        chk(32'(cmp_out_ext[0]), 32'h0);
        @(posedge ref_clk);
        gate_tmr_clk <= 1'b0;
        cyc(3);
        chk(32'(cmp_out_ext[0]), 32'h1);
        bus(1, OFS_CTRL0_BASE, 32'h80);
        cmp_raw[0] <= 1'b0;
        cyc(2);
        chk(32'(cmp_out_ext[0]), 32'h0);
        $display("test sync done");
        stop_test();
    end
endmodule
